//--- src/pin_mux_pkg.sv
// Shared constants and types for the multipurpose pin function multiplexer
package pin_mux_pkg;

  // ***************************************************************
  // Function codes of the second multipurpose pin (pin two)
  // ***************************************************************
  localparam logic [3:0] PIN2_INTERRUPT = 4'h0;
  localparam logic [3:0] PIN2_REF0_ACTIVITY = 4'h1;
  localparam logic [3:0] PIN2_DL0_HOLDOVER = 4'h2;
  localparam logic [3:0] PIN2_DL1_HOLDOVER = 4'h3;
  localparam logic [3:0] PIN2_DL0_LOCK = 4'h4;
  localparam logic [3:0] PIN2_DL1_LOCK = 4'h5;
  localparam logic [3:0] PIN2_AL0_LOCK = 4'h6;
  localparam logic [3:0] PIN2_RF_LOCK = 4'h7;
  localparam logic [3:0] PIN2_DL0_REF_SELECT = 4'h8;

  // ***************************************************************
  // Function codes of the third multipurpose pin (pin three)
  // ***************************************************************
  localparam logic [3:0] PIN3_INTERRUPT = 4'h0;
  localparam logic [3:0] PIN3_REF0_ACTIVITY = 4'h1;
  localparam logic [3:0] PIN3_REF1_ACTIVITY = 4'h2;
  localparam logic [3:0] PIN3_READY = 4'h3;
  localparam logic [3:0] PIN3_DL0_LOCK = 4'h4;
  localparam logic [3:0] PIN3_DL1_LOCK = 4'h5;
  localparam logic [3:0] PIN3_AL1_LOCK = 4'h6;
  localparam logic [3:0] PIN3_AL2_LOCK = 4'h7;
  localparam logic [3:0] PIN3_DL1_REF_SELECT = 4'h8;

  // ***************************************************************
  // Shared codes, field positions and counts
  // ***************************************************************
  localparam logic [3:0] SEL_OE_FIRST = 4'h9;
  localparam int SEL_INPUT_BIT = 3;
  localparam int OE_GROUPS = 7;
  localparam int STATUS_WIDTH = 8;

  // ***************************************************************
  // Reset values and startup timing
  // ***************************************************************
  localparam logic [3:0] PIN2_SELECT_RESET = 4'h6;
  localparam logic [3:0] PIN3_SELECT_RESET = 4'h3;
  localparam logic [1:0] BOOT_CONFIG_RESET = 2'h0;
  localparam logic FILTER_RESET = 1'b0;
  localparam logic [2:0] SAMPLE_WAIT = 3'h4;

  // Startup sequence, Gray coded along the path
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN = 2'b11
  } startup_state_t;

endpackage

//--- src/pin_input_filter.sv
// Three-stage input synchroniser whose output follows once stages two and three agree
`timescale 1ns/1ns
module pin_input_filter (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Asynchronous pin level
  input wire logic pinIn,
  // Filtered level in the mclk domain
  output logic filtered
);

  logic stageOne;
  logic stageTwo;
  logic stageThree;
  logic next_filtered;

  // A single-cycle disagreement is treated as a glitch and ignored
  always_comb begin
    next_filtered = (stageTwo == stageThree) ? stageThree : filtered;
  end

  // Stage one feeds only stage two, so metastability cannot spread
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stageOne <= pin_mux_pkg::FILTER_RESET;
      stageTwo <= pin_mux_pkg::FILTER_RESET;
      stageThree <= pin_mux_pkg::FILTER_RESET;
      filtered <= pin_mux_pkg::FILTER_RESET;
    end else begin
      stageOne <= pinIn;
      stageTwo <= stageOne;
      stageThree <= stageTwo;
      filtered <= next_filtered;
    end
  end

endmodule // pin_input_filter

//--- src/pin_function_mux.sv
// Decodes one pin's function code into its output value and drive direction
`timescale 1ns/1ns
module pin_function_mux (
  // Function code of the pin
  input wire logic [3:0] code,
  // Status bits ordered by output function code
  input wire logic [7:0] status,
  // Pin value and direction
  output logic value,
  output logic drives
);

  // Codes with the top bit set make the pin an input
  always_comb begin
    drives = !code[pin_mux_pkg::SEL_INPUT_BIT];
    value = drives ? status[code[2:0]] : 1'b0;
  end

endmodule // pin_function_mux

//--- src/status_pin_function_mux.sv
// Multipurpose pin function multiplexer with startup sampling and status reporting
//
// Notes on behaviour
// [RULE_01] Pin two code 0110 drives analog loop zero lock state.
// [RULE_02] Pin two code 0111 drives the RF synthesizer loop lock state.
// [RULE_03] Pin two code 1000 is an input choosing digital loop zero reference.
// [RULE_04] Codes 1001 to 1111 on pin two or three enable output groups 0 to 6.
// [RULE_05] Low enable pin leaves register bits in charge; high forces group enabled.
// [RULE_06] Pin three code 0000 drives the pending interrupt level.
// [RULE_07] Pin three code 0001 drives reference zero valid.
// [RULE_08] Pin three code 0010 drives reference one valid.
// [RULE_09] Pin three code 0011 drives the device ready level.
// [RULE_10] Pin three codes 0100 and 0101 drive digital loop zero and one lock.
// [RULE_11] Pin three code 0110 drives analog loop one lock state.
// [RULE_12] Pin three code 0111 drives analog loop two lock state.
// [RULE_13] Pin three code 1000 is an input choosing digital loop one reference.
// [RULE_14] Pins zero and one are inputs at startup, sampled after reset release.
// [RULE_15] The sampled two bits choose one of four stored configurations.
// [RULE_16] With no resistors fitted the startup selection defaults to 00.
// [RULE_17] During startup pins two and three are always driven outputs.
// [RULE_18] At startup pin two shows analog loop zero lock.
// [RULE_19] At startup pin three shows ready: low until initialization completes.
// [RULE_20] Ready on pin three mirrors the device ready status bit.
// [RULE_21] Pin-derived startup settings stay writable by later serial accesses.
// [RULE_22] After startup each pin's direction follows its function code.
`timescale 1ns/1ns
module status_pin_function_mux (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Multipurpose pins
  input wire logic multipurposePinZeroIn,
  input wire logic multipurposePinOneIn,
  input wire logic multipurposePinTwoIn,
  output logic multipurposePinTwoOut,
  output logic multipurposePinTwoOe,
  input wire logic multipurposePinThreeIn,
  output logic multipurposePinThreeOut,
  output logic multipurposePinThreeOe,
  // Status from the device core
  input wire logic interruptPending,
  input wire logic refZeroValid,
  input wire logic refOneValid,
  input wire logic digitalLoopZeroHoldover,
  input wire logic digitalLoopOneHoldover,
  input wire logic digitalLoopZeroLocked,
  input wire logic digitalLoopOneLocked,
  input wire logic analogLoopZeroLocked,
  input wire logic analogLoopOneLocked,
  input wire logic analogLoopTwoLocked,
  input wire logic rfSynthLoopLocked,
  input wire logic deviceReadyStatusBit,
  // Serial port register access
  input wire logic pin2SelectWrite,
  input wire logic [3:0] pin2SelectData,
  input wire logic pin3SelectWrite,
  input wire logic [3:0] pin3SelectData,
  input wire logic bootConfigWrite,
  input wire logic [1:0] bootConfigData,
  output logic [3:0] pin2FunctionSelect,
  output logic [3:0] pin3FunctionSelect,
  output logic [1:0] bootConfigSelect,
  // Configuration loader
  output logic bootConfigLoad,
  output logic startupDone,
  // Reference selection and output group enables
  input wire logic [6:0] registerOutputEnable,
  output logic digitalLoopZeroRefSelect,
  output logic digitalLoopZeroRefPinMode,
  output logic digitalLoopOneRefSelect,
  output logic digitalLoopOneRefPinMode,
  output logic [6:0] groupOutputEnable
);

  // ***************************************************************
  // Pin input synchronisers
  // ***************************************************************
  logic [3:0] pinRaw;
  logic [3:0] pinFilt;

  assign pinRaw = {multipurposePinThreeIn, multipurposePinTwoIn, multipurposePinOneIn, multipurposePinZeroIn};

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_filter
      pin_input_filter u_filter (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinIn(pinRaw[p]),
        .filtered(pinFilt[p])
      );
    end
  endgenerate

  // ***************************************************************
  // Startup sequence
  // ***************************************************************
  pin_mux_pkg::startup_state_t state, next_state;
  logic [2:0] sampleCount, next_sampleCount;
  logic captureNow, run;

  // Capture waits until the filters have seen the released pins
  assign captureNow = (state == pin_mux_pkg::ST_SAMPLE) && (sampleCount == pin_mux_pkg::SAMPLE_WAIT);
  assign run = (state == pin_mux_pkg::ST_RUN);

  // Sample, then wait for the core to report ready
  always_comb begin
    next_state = state;
    next_sampleCount = sampleCount;
    case (state)
      pin_mux_pkg::ST_SAMPLE: begin
        next_sampleCount = sampleCount + 3'h1;
        if (captureNow) begin
          next_state = pin_mux_pkg::ST_LOAD; // RULE_14
        end
      end
      pin_mux_pkg::ST_LOAD: begin
        if (deviceReadyStatusBit) begin
          next_state = pin_mux_pkg::ST_RUN;
        end
      end
      pin_mux_pkg::ST_RUN: begin
        next_state = pin_mux_pkg::ST_RUN;
      end
      default: begin
        next_state = pin_mux_pkg::ST_SAMPLE;
      end
    endcase
  end

  // Sequence registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pin_mux_pkg::ST_SAMPLE;
      sampleCount <= 3'h0;
    end else begin
      state <= next_state;
      sampleCount <= next_sampleCount;
    end
  end

  // ***************************************************************
  // Function select and startup configuration registers
  // ***************************************************************
  logic [3:0] next_pin2FunctionSelect, next_pin3FunctionSelect;
  logic [1:0] next_bootConfigSelect;
  logic next_bootConfigLoad;

  // A serial write in the capture cycle wins, since it is the newer intent
  always_comb begin
    next_pin2FunctionSelect = pin2SelectWrite ? pin2SelectData : pin2FunctionSelect; // RULE_21
    next_pin3FunctionSelect = pin3SelectWrite ? pin3SelectData : pin3FunctionSelect; // RULE_21
    next_bootConfigSelect = bootConfigSelect;
    if (bootConfigWrite) begin
      next_bootConfigSelect = bootConfigData; // RULE_21
    end else if (captureNow) begin
      next_bootConfigSelect = {pinFilt[1], pinFilt[0]}; // RULE_15
    end
    next_bootConfigLoad = captureNow; // RULE_15
  end

  // Reset values are the startup functions; pulled-down pins read 00
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin2FunctionSelect <= pin_mux_pkg::PIN2_SELECT_RESET;
      pin3FunctionSelect <= pin_mux_pkg::PIN3_SELECT_RESET;
      bootConfigSelect <= pin_mux_pkg::BOOT_CONFIG_RESET; // RULE_16
      bootConfigLoad <= 1'b0;
    end else begin
      pin2FunctionSelect <= next_pin2FunctionSelect;
      pin3FunctionSelect <= next_pin3FunctionSelect;
      bootConfigSelect <= next_bootConfigSelect;
      bootConfigLoad <= next_bootConfigLoad;
    end
  end

  // ***************************************************************
  // Output functions of pins two and three
  // ***************************************************************
  logic [7:0] pin2Status, pin3Status;
  logic pin2Value, pin2Drives, pin3Value, pin3Drives;
  logic next_pinTwoOut, next_pinTwoOe, next_pinThreeOut, next_pinThreeOe, next_startupDone;

  // Status bits placed at the position of their function code
  assign pin2Status = {rfSynthLoopLocked, analogLoopZeroLocked, digitalLoopOneLocked, digitalLoopZeroLocked,
                       digitalLoopOneHoldover, digitalLoopZeroHoldover, refZeroValid, interruptPending};
  assign pin3Status = {analogLoopTwoLocked, analogLoopOneLocked, digitalLoopOneLocked, digitalLoopZeroLocked,
                       deviceReadyStatusBit, refOneValid, refZeroValid, interruptPending};

  pin_function_mux u_pin2_mux (
    .code(pin2FunctionSelect),
    .status(pin2Status),
    .value(pin2Value),
    .drives(pin2Drives)
  );

  pin_function_mux u_pin3_mux (
    .code(pin3FunctionSelect),
    .status(pin3Status),
    .value(pin3Value),
    .drives(pin3Drives)
  );

  // Startup forces fixed status outputs whatever the selectors hold
  always_comb begin
    if (run) begin
      next_pinTwoOut = pin2Value; // RULE_01 RULE_02
      next_pinTwoOe = pin2Drives; // RULE_22
      next_pinThreeOut = pin3Value; // RULE_06 RULE_07 RULE_08 RULE_09 RULE_10 RULE_11 RULE_12
      next_pinThreeOe = pin3Drives; // RULE_22
    end else begin
      next_pinTwoOut = analogLoopZeroLocked; // RULE_18
      next_pinTwoOe = 1'b1; // RULE_17
      next_pinThreeOut = deviceReadyStatusBit; // RULE_19 RULE_20
      next_pinThreeOe = 1'b1; // RULE_17
    end
    next_startupDone = run;
  end

  // Pins are driven from flops so they never glitch on selector changes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      multipurposePinTwoOut <= 1'b0;
      multipurposePinTwoOe <= 1'b1;
      multipurposePinThreeOut <= 1'b0;
      multipurposePinThreeOe <= 1'b1;
      startupDone <= 1'b0;
    end else begin
      multipurposePinTwoOut <= next_pinTwoOut;
      multipurposePinTwoOe <= next_pinTwoOe;
      multipurposePinThreeOut <= next_pinThreeOut;
      multipurposePinThreeOe <= next_pinThreeOe;
      startupDone <= next_startupDone;
    end
  end

  // ***************************************************************
  // Input functions of pins two and three
  // ***************************************************************
  logic next_dl0RefSelect, next_dl0PinMode, next_dl1RefSelect, next_dl1PinMode;
  logic [6:0] next_groupOutputEnable;

  // Reference selection only counts after startup, when the pin is released
  always_comb begin
    next_dl0PinMode = run && (pin2FunctionSelect == pin_mux_pkg::PIN2_DL0_REF_SELECT);
    next_dl0RefSelect = next_dl0PinMode && pinFilt[2]; // RULE_03
    next_dl1PinMode = run && (pin3FunctionSelect == pin_mux_pkg::PIN3_DL1_REF_SELECT);
    next_dl1RefSelect = next_dl1PinMode && pinFilt[3]; // RULE_13
  end

  // One enable term per output group; either pin may force it on
  genvar g;
  generate
    for (g = 0; g < pin_mux_pkg::OE_GROUPS; g++) begin : g_group
      localparam logic [3:0] GROUP_CODE = 4'(pin_mux_pkg::SEL_OE_FIRST + 4'(g));
      always_comb begin
        next_groupOutputEnable[g] = registerOutputEnable[g] // RULE_05
          || (run && (pin2FunctionSelect == GROUP_CODE) && pinFilt[2]) // RULE_04
          || (run && (pin3FunctionSelect == GROUP_CODE) && pinFilt[3]); // RULE_04
      end
    end
  endgenerate

  // Input function results
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      digitalLoopZeroRefSelect <= 1'b0;
      digitalLoopZeroRefPinMode <= 1'b0;
      digitalLoopOneRefSelect <= 1'b0;
      digitalLoopOneRefPinMode <= 1'b0;
      groupOutputEnable <= 7'h00;
    end else begin
      digitalLoopZeroRefSelect <= next_dl0RefSelect;
      digitalLoopZeroRefPinMode <= next_dl0PinMode;
      digitalLoopOneRefSelect <= next_dl1RefSelect;
      digitalLoopOneRefPinMode <= next_dl1PinMode;
      groupOutputEnable <= next_groupOutputEnable;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  property p_pin2_al0_lock;
    @(posedge mclk) disable iff (!rst_n)
    (run && pin2FunctionSelect == pin_mux_pkg::PIN2_AL0_LOCK) |=>
      multipurposePinTwoOut == $past(analogLoopZeroLocked) && multipurposePinTwoOe;
  endproperty
  a_pin2_al0_lock: assert property (p_pin2_al0_lock) else $error("pin two not showing analog loop zero lock"); // RULE_01
  property p_pin2_rf_lock;
    @(posedge mclk) disable iff (!rst_n)
    (run && pin2FunctionSelect == pin_mux_pkg::PIN2_RF_LOCK) |=> multipurposePinTwoOut == $past(rfSynthLoopLocked);
  endproperty
  a_pin2_rf_lock: assert property (p_pin2_rf_lock) else $error("pin two not showing rf loop lock"); // RULE_02
  property p_dl0_ref_select;
    @(posedge mclk) disable iff (!rst_n)
    (run && pin2FunctionSelect == pin_mux_pkg::PIN2_DL0_REF_SELECT) |=>
      !multipurposePinTwoOe && digitalLoopZeroRefPinMode && digitalLoopZeroRefSelect == $past(pinFilt[2]);
  endproperty
  a_dl0_ref_select: assert property (p_dl0_ref_select) else $error("loop zero reference select wrong"); // RULE_03
  property p_group_forced;
    @(posedge mclk) disable iff (!rst_n)
    run && (pin2FunctionSelect == pin_mux_pkg::SEL_OE_FIRST && pinFilt[2]
      || pin3FunctionSelect == pin_mux_pkg::SEL_OE_FIRST && pinFilt[3]) |=> groupOutputEnable[0];
  endproperty
  a_group_forced: assert property (p_group_forced) else $error("enable pin did not force group zero on"); // RULE_04
  property p_group_register;
    @(posedge mclk) disable iff (!rst_n)
    !run |=> groupOutputEnable == $past(registerOutputEnable);
  endproperty
  a_group_register: assert property (p_group_register) else $error("group enables not from register bits"); // RULE_05
  property p_pin3_interrupt;
    @(posedge mclk) disable iff (!rst_n)
    (run && pin3FunctionSelect == pin_mux_pkg::PIN3_INTERRUPT) |=> multipurposePinThreeOut == $past(interruptPending);
  endproperty
  a_pin3_interrupt: assert property (p_pin3_interrupt) else $error("pin three not showing interrupt"); // RULE_06
  property p_pin3_ref1;
    @(posedge mclk) disable iff (!rst_n)
    (run && pin3FunctionSelect == pin_mux_pkg::PIN3_REF1_ACTIVITY) |=> multipurposePinThreeOut == $past(refOneValid);
  endproperty
  a_pin3_ref1: assert property (p_pin3_ref1) else $error("pin three not showing reference one activity"); // RULE_08
  property p_pin3_dl1_lock;
    @(posedge mclk) disable iff (!rst_n)
    (run && pin3FunctionSelect == pin_mux_pkg::PIN3_DL1_LOCK) |=>
      multipurposePinThreeOut == $past(digitalLoopOneLocked);
  endproperty
  a_pin3_dl1_lock: assert property (p_pin3_dl1_lock) else $error("pin three not showing loop one lock"); // RULE_10
  property p_pin3_al2_lock;
    @(posedge mclk) disable iff (!rst_n)
    (run && pin3FunctionSelect == pin_mux_pkg::PIN3_AL2_LOCK) |=>
      multipurposePinThreeOut == $past(analogLoopTwoLocked);
  endproperty
  a_pin3_al2_lock: assert property (p_pin3_al2_lock) else $error("pin three not showing analog loop two lock"); // RULE_12
  property p_capture;
    @(posedge mclk) disable iff (!rst_n)
    (captureNow && !bootConfigWrite) |=> bootConfigLoad && bootConfigSelect == $past({pinFilt[1], pinFilt[0]});
  endproperty
  a_capture: assert property (p_capture) else $error("startup pins not captured"); // RULE_15
  property p_capture_time;
    @(posedge mclk) disable iff (!rst_n)
    $rose(state == pin_mux_pkg::ST_LOAD) |-> $past(state == pin_mux_pkg::ST_SAMPLE, 1) && bootConfigLoad;
  endproperty
  a_capture_time: assert property (p_capture_time) else $error("load began without a capture"); // RULE_14
  property p_startup_outputs;
    @(posedge mclk) disable iff (!rst_n)
    !run |=> multipurposePinTwoOe && multipurposePinThreeOe && multipurposePinTwoOut == $past(analogLoopZeroLocked);
  endproperty
  a_startup_outputs: assert property (p_startup_outputs) else $error("startup pin outputs wrong"); // RULE_17
  property p_ready_mirror;
    @(posedge mclk) disable iff (!rst_n)
    !run |=> multipurposePinThreeOut == $past(deviceReadyStatusBit);
  endproperty
  a_ready_mirror: assert property (p_ready_mirror) else $error("ready pin does not mirror status bit"); // RULE_20
  property p_select_write;
    @(posedge mclk) disable iff (!rst_n)
    pin3SelectWrite |=> pin3FunctionSelect == $past(pin3SelectData);
  endproperty
  a_select_write: assert property (p_select_write) else $error("pin three select write lost"); // RULE_21
  property p_direction;
    @(posedge mclk) disable iff (!rst_n)
    run |=> multipurposePinTwoOe == !$past(pin2FunctionSelect[3])
      && multipurposePinThreeOe == !$past(pin3FunctionSelect[3]);
  endproperty
  a_direction: assert property (p_direction) else $error("pin direction does not follow its code"); // RULE_22

endmodule // status_pin_function_mux

//--- bench/pin_host_model.sv
// Board-side model of the logic that drives, pulls and watches the multipurpose pins
`timescale 1ns/1ns
module pin_host_model (
  // Host drive requests
  input wire logic [3:0] hostDrive,
  input wire logic [3:0] hostLevel,
  // Device pin drivers
  input wire logic pinTwoOut,
  input wire logic pinTwoOe,
  input wire logic pinThreeOut,
  input wire logic pinThreeOe,
  // Resolved pin levels
  output logic [3:0] pinLevel
);
  // ****************
  // Wire resolution
  // ****************
  // Undriven pins fall to the pull-down level, never a stale value
  assign pinLevel[0] = hostDrive[0] ? hostLevel[0] : 1'b0;
  assign pinLevel[1] = hostDrive[1] ? hostLevel[1] : 1'b0;
  // Two drivers at once show as unknown so contention cannot hide
  // No pull on these pins, so a floating pin shows the inverse of the last host level
  assign pinLevel[2] = (pinTwoOe & hostDrive[2]) ? 1'bx
    : (pinTwoOe ? pinTwoOut : (hostDrive[2] ? hostLevel[2] : !hostLevel[2]));
  assign pinLevel[3] = (pinThreeOe & hostDrive[3]) ? 1'bx
    : (pinThreeOe ? pinThreeOut : (hostDrive[3] ? hostLevel[3] : !hostLevel[3]));
endmodule // pin_host_model

//--- bench/status_pin_function_mux_tb_top.sv
// Self-checking testbench for the multipurpose pin function multiplexer
`timescale 1ns/1ns
module status_pin_function_mux_tb_top;
  // ****************
  // Stimulus and observed signals
  // ****************
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] stat = 12'h000;
  logic [3:0] hostDrive = 4'h0;
  logic [3:0] hostLevel = 4'h0;
  logic [3:0] pinLevel;
  logic p2Wr = 1'b0, p3Wr = 1'b0, bcWr = 1'b0;
  logic [3:0] wrData = 4'h0;
  logic [6:0] regEn = 7'h00;
  logic p2Out, p2Oe, p3Out, p3Oe, bcLoad, done, r0Sel, r0Mode, r1Sel, r1Mode;
  logic [3:0] p2Sel, p3Sel;
  logic [1:0] bcSel;
  logic [6:0] grpEn;
  int errorCnt = 0;
  int samplesChecked = 0;

  always #20 mclk = ~mclk;

  status_pin_function_mux uut (.mclk(mclk), .rst_n(rst_n), .multipurposePinZeroIn(pinLevel[0]),
    .multipurposePinOneIn(pinLevel[1]), .multipurposePinTwoIn(pinLevel[2]), .multipurposePinTwoOut(p2Out),
    .multipurposePinTwoOe(p2Oe), .multipurposePinThreeIn(pinLevel[3]), .multipurposePinThreeOut(p3Out),
    .multipurposePinThreeOe(p3Oe), .interruptPending(stat[0]), .refZeroValid(stat[1]), .refOneValid(stat[2]),
    .digitalLoopZeroHoldover(stat[3]), .digitalLoopOneHoldover(stat[4]), .digitalLoopZeroLocked(stat[5]),
    .digitalLoopOneLocked(stat[6]), .analogLoopZeroLocked(stat[7]), .analogLoopOneLocked(stat[8]),
    .analogLoopTwoLocked(stat[9]), .rfSynthLoopLocked(stat[10]), .deviceReadyStatusBit(stat[11]),
    .pin2SelectWrite(p2Wr), .pin2SelectData(wrData), .pin3SelectWrite(p3Wr), .pin3SelectData(wrData),
    .bootConfigWrite(bcWr), .bootConfigData(wrData[1:0]), .pin2FunctionSelect(p2Sel), .pin3FunctionSelect(p3Sel),
    .bootConfigSelect(bcSel), .bootConfigLoad(bcLoad), .startupDone(done), .registerOutputEnable(regEn),
    .digitalLoopZeroRefSelect(r0Sel), .digitalLoopZeroRefPinMode(r0Mode), .digitalLoopOneRefSelect(r1Sel),
    .digitalLoopOneRefPinMode(r1Mode), .groupOutputEnable(grpEn));

  pin_host_model host (.hostDrive(hostDrive), .hostLevel(hostLevel), .pinTwoOut(p2Out), .pinTwoOe(p2Oe),
    .pinThreeOut(p3Out), .pinThreeOe(p3Oe), .pinLevel(pinLevel));

  // ****************
  // Shared tasks
  // ****************
  task automatic checkVec(input string what, input logic [6:0] exp, input logic [6:0] got);
    samplesChecked++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic checkBit(input string what, input logic exp, input logic got);
    checkVec(what, {6'h00, exp}, {6'h00, got});
  endtask
  // Inputs move 1 ns after the edge so no race with the design's sampling
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Target 2 or 3 is a pin selector, 0 the startup configuration select
  task automatic wrSel(input logic [1:0] target, input logic [3:0] v);
    wrData = v;
    p2Wr = (target == 2'h2);
    p3Wr = (target == 2'h3);
    bcWr = (target == 2'h0);
    step(1);
    p2Wr = 1'b0;
    p3Wr = 1'b0;
    bcWr = 1'b0;
    step(1); // Idle cycle so a following write never re-raises a strobe in the same time step
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  // Reset, capture of the startup pins and the fixed startup status outputs
  task automatic boot(input logic [1:0] pins, input logic drv, input logic [1:0] exp);
    int n;
    rst_n = 1'b0;
    stat = 12'h000;
    hostDrive = {2'h0, drv, drv};
    hostLevel = {2'h0, pins};
    step(20);
    rst_n = 1'b1;
    for (n = 0; n < 20 && bcLoad !== 1'b1; n++) step(1);
    checkBit("load seen", 1'b1, n < 20);
    checkVec("boot select", {5'h00, exp}, {5'h00, bcSel});
    hostLevel = ~hostLevel;
    stat[7] = 1'b1;
    step(8);
    checkVec("late pins ignored", {5'h00, exp}, {5'h00, bcSel});
    checkVec("startup oe", 7'h03, {5'h00, p2Oe, p3Oe});
    checkVec("startup pins", 7'h02, {5'h00, p2Out, p3Out});
    stat[11] = 1'b1;
    step(3);
    checkVec("ready pins", 7'h07, {4'h0, p2Out, p3Out, done});
    checkVec("select resets", 7'h33, {p2Sel, p3Sel[2:0]});
    $display("test boot done");
  endtask

  // Every pin three output code and pin two codes 0110 and 0111, each with its source alone high then alone low
  task automatic outFunctions;
    int src[10] = '{0, 1, 2, 11, 5, 6, 8, 9, 7, 10};
    for (int c = 0; c < 10; c++) begin
      wrSel(c < 8 ? 2'h3 : 2'h2, c < 8 ? c[3:0] : c[3:0] - 4'h2);
      stat = 12'h001 << src[c];
      step(2);
      checkVec("out high", 7'h03, {5'h00, c < 8 ? {p3Oe, p3Out} : {p2Oe, p2Out}});
      stat = ~(12'h001 << src[c]);
      step(2);
      checkBit("out low", 1'b0, c < 8 ? p3Out : p2Out);
    end
    $display("test outputs done");
  endtask

  // Reference selection and forced output group enables from pin inputs
  task automatic inFunctions;
    wrSel(2'h2, 4'h8);
    wrSel(2'h3, 4'h8);
    step(1);
    checkVec("released oe", 7'h00, {5'h00, p2Oe, p3Oe});
    hostDrive = 4'hc;
    for (int k = 1; k < 3; k++) begin
      hostLevel = {k[1:0], 2'h0};
      step(8);
      checkVec("ref select", {3'h0, k[0], 1'b1, k[1], 1'b1}, {3'h0, r0Sel, r0Mode, r1Sel, r1Mode});
    end
    regEn = 7'h55;
    for (int g = 0; g < 7; g++) begin
      wrSel(g[0] ? 2'h2 : 2'h3, 4'h8);
      wrSel(g[0] ? 2'h3 : 2'h2, 4'h9 + g[3:0]);
      hostLevel = 4'hc;
      step(8);
      checkVec("group forced", 7'h55 | (7'h01 << g), grpEn);
      hostLevel = 4'h0;
      step(8);
      checkVec("group register", 7'h55, grpEn);
    end
    hostDrive = 4'h0;
    wrSel(2'h0, 4'h3);
    checkVec("boot select write", 7'h03, {5'h00, bcSel});
    $display("test inputs done");
  endtask

  // ****************
  // Main sequence and watchdog
  // ****************
  initial begin
    boot(2'h2, 1'b1, 2'h2);
    outFunctions();
    inFunctions();
    boot(2'h3, 1'b0, 2'h0);
    complete_run();
  end
  // A hang ends in the same report rather than running forever
  initial begin
    #2000000;
    errorCnt++;
    complete_run();
  end
endmodule // status_pin_function_mux_tb_top
